// *** verilog/dcap_map.svh ***
// Register offsets, field positions, reset values and counts of the DRAM command port.
// What this block does
// - Activate takes the row; read and write take column and auto-precharge bit.
// - Precharge closes the addressed bank, or every bank when bit ten is high.
// - With on-the-fly chop enabled, bit twelve high gives 8 beats, low gives 4.
// - A load-mode command takes the mode register value from the address pins.
// - Bank pins pick which of mode registers zero to three is loaded.
// - Activate, read, write and precharge act on the bank the bank pins name.
// - Every command and control pin is captured on the rising clock edge.
// - Clock enable low enters precharge power-down, self refresh or active power-down.
// - Power-down and self refresh entry and exit are all synchronous; both exits take the clock enable level alone.
// - In power-down only clock, clock enable, reset and termination enable are heard.
// - In self refresh only clock enable and reset are heard.
// - Sixteen row bits, three bank bits; columns differ between x4 and x8.
// - Two ranks, each with its own select, clock enable and termination enable.
// - Each rank has eight banks, each holding its own open row.
// - The data strobe is timed from the clock.
// - A rank decodes only while its select is low.
// - Row strobe, column strobe, write enable and select form the command.
// - A write beat sampled with its mask high is discarded.
// - Termination follows termination enable unless mode register one disables it.
`ifndef DCAP_MAP_SVH
`define DCAP_MAP_SVH
`define DCAP_OFS_CTRL 8'h00
`define DCAP_OFS_STATUS 8'h04
`define DCAP_OFS_LASTCMD 8'h08
`define DCAP_OFS_LASTADR 8'h0c
`define DCAP_OFS_REFCNT 8'h10
`define DCAP_OFS_MODE 8'h20
`define DCAP_OFS_MODE_END 8'h3c
`define DCAP_CTRL_X8_BIT 0
`define DCAP_CTRL_RST 1'b0
`define DCAP_MODE_RST 16'h0000
`define DCAP_AP_BIT 10
`define DCAP_CHOP_BIT 12
`define DCAP_MODE_ZERO_LEN_LSB 0
`define DCAP_LEN_FIX8 2'h0
`define DCAP_LEN_OTF 2'h1
`define DCAP_LEN_FIX4 2'h2
`define DCAP_LEN_RSVD 2'h3
`define DCAP_MODE_ONE_TERM_A 2
`define DCAP_MODE_ONE_TERM_B 6
`define DCAP_MODE_ONE_TERM_C 9
`define DCAP_BEATS8 4'h8
`define DCAP_BEATS4 4'h4
`define DCAP_RESP_OKAY 2'h0
`define DCAP_RESP_SLVERR 2'h2
`endif

// *** verilog/dcap_pkg.sv ***
// Types shared by the DRAM command port.
package dcap_pkg;
	typedef enum logic [1:0] {
		PW_ACTIVE = 2'b00,
		PW_PRE_PD = 2'b01,
		PW_ACT_PD = 2'b10,
		PW_SELF_REF = 2'b11
	} dcap_power_t;
	typedef enum logic [2:0] {
		CMD_LOAD_MODE = 3'b000,
		CMD_REFRESH = 3'b001,
		CMD_PRECHARGE = 3'b010,
		CMD_ACTIVATE = 3'b011,
		CMD_WRITE = 3'b100,
		CMD_READ = 3'b101,
		CMD_CALIB = 3'b110,
		CMD_NOP = 3'b111
	} dcap_cmd_t;
	typedef struct packed {
		logic [1:0] cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [2:0] ba;
		logic [15:0] addr;
	} dcap_ca_t;
	typedef struct packed {
		logic rank;
		dcap_cmd_t kind;
		logic [2:0] bank;
		logic auto_pre;
		logic burst8;
		logic [15:0] row;
		logic [11:0] col;
	} dcap_report_t;
endpackage

// *** verilog/dcap_mode_mem.sv ***
// Storage for the mode registers of both ranks, registered read port.
`timescale 1ns/10ps
module dcap_mode_mem #(
	parameter int WORDS = 8,
	parameter int W = 16
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Write port.
	input wire logic we,
	input wire logic [$clog2(WORDS)-1:0] waddr,
	input wire logic [W-1:0] wdata,
	// Read port.
	input wire logic [$clog2(WORDS)-1:0] raddr,
	output logic [W-1:0] rdata
);
	logic [W-1:0] mem_r [WORDS];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < WORDS; i++) begin
				mem_r[i] <= W'(0);
			end
		end else if (we) begin
			mem_r[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk) begin
		rdata <= mem_r[raddr];
	end
endmodule // dcap_mode_mem

// *** verilog/dcap_bank_table.sv ***
// Open-row state of the banks of one rank.
`timescale 1ns/10ps
module dcap_bank_table #(
	parameter int BANKS = 8,
	parameter int ROW_W = 16
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Bank commands.
	input wire logic act,
	input wire logic pre_one,
	input wire logic pre_all,
	input wire logic [$clog2(BANKS)-1:0] bank,
	input wire logic [ROW_W-1:0] row,
	// State.
	output logic [BANKS-1:0] open_mask,
	output logic [ROW_W-1:0] sel_row
);
	logic [ROW_W-1:0] row_r [BANKS];

	for (genvar b = 0; b < BANKS; b++) begin : g_bank
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				open_mask[b] <= 1'b0;
				row_r[b] <= ROW_W'(0);
			end else if (act && bank == b) begin
				open_mask[b] <= 1'b1;
				row_r[b] <= row;
			end else if (pre_all || (pre_one && bank == b)) begin
				open_mask[b] <= 1'b0;
			end
		end
	end

	assign sel_row = row_r[bank];
endmodule // dcap_bank_table

// *** verilog/dcap_top.sv ***
// Command, address and control decode of a two-rank DRAM with register access.
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "dcap_map.svh"
module dcap_top
	import dcap_pkg::*;
#(
	parameter int DATA_W = 8,
	parameter int BANKS = 8
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus, write side.
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// Register bus, read side.
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Command, address and control pins.
	input wire dcap_ca_t ca,
	input wire logic [1:0] cke,
	input wire logic [1:0] termination_enable,
	input wire logic dram_reset_n,
	// Write data pins.
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic write_byte_mask,
	// Outputs toward the array and the pads.
	output logic [1:0] term_on,
	output logic dqs_out,
	output logic wr_beat_valid,
	output logic [DATA_W-1:0] wr_beat_data,
	output logic cmd_valid,
	output dcap_report_t cmd_report
);
	// ==========================================================
	// Command decode
	// ==========================================================
	dcap_cmd_t kind;
	logic [1:0] dec;
	logic [1:0] cke_q_r;
	logic [3:0] pw_bits;
	logic [BANKS-1:0] open_w [2];
	logic [15:0] row_w [2];
	logic [15:0] mode_reg_zero_r [2];
	logic [15:0] mode_reg_one_r [2];
	logic rank_sel;
	logic [11:0] col;
	logic burst8;
	logic org_x8_r;

	assign kind = dcap_cmd_t'({ca.ras_n, ca.cas_n, ca.we_n});
	// Rank zero wins if both selects are low; the controller must not do that.
	assign rank_sel = !dec[0];
	assign col = org_x8_r ? {1'b0, ca.addr[11], ca.addr[9:0]} :
		{ca.addr[13], ca.addr[11], ca.addr[9:0]};

	always_comb begin
		unique case (mode_reg_zero_r[rank_sel][`DCAP_MODE_ZERO_LEN_LSB +: 2])
			`DCAP_LEN_FIX8: burst8 = 1'b1;
			`DCAP_LEN_OTF: burst8 = ca.addr[`DCAP_CHOP_BIT];
			`DCAP_LEN_FIX4: burst8 = 1'b0;
			`DCAP_LEN_RSVD: burst8 = 1'b1;
		endcase
	end

	// Pins are sampled on the rising aclk edge, which stands for the clock crossing.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cke_q_r <= 2'h0;
		end else begin
			cke_q_r <= cke;
		end
	end

	// ==========================================================
	// Per-rank power state and bank tables
	// ==========================================================
	for (genvar r = 0; r < 2; r++) begin : g_rank
		dcap_power_t pw_r;
		logic is_rw;

		assign pw_bits[2*r +: 2] = pw_r;
		// Receivers other than clock enable, reset and, in power-down, termination enable are off outside the active state.
		assign dec[r] = !ca.cs_n[r] && pw_r == PW_ACTIVE && cke[r] && dram_reset_n;
		assign is_rw = kind == CMD_READ || kind == CMD_WRITE;

		always_ff @(posedge aclk) begin
			if (!aresetn || !dram_reset_n) begin
				pw_r <= PW_ACTIVE;
			end else begin
				unique case (pw_r)
					PW_ACTIVE: begin
						if (cke_q_r[r] && !cke[r]) begin
							if (!ca.cs_n[r] && kind == CMD_REFRESH) begin
								pw_r <= PW_SELF_REF;
							end else if (|open_w[r]) begin
								pw_r <= PW_ACT_PD;
							end else begin
								pw_r <= PW_PRE_PD;
							end
						end
					end
					PW_PRE_PD, PW_ACT_PD: begin
						if (cke[r]) begin
							pw_r <= PW_ACTIVE;
						end
					end
					// Exit needs no clock history: the raw level alone releases it.
					PW_SELF_REF: begin
						if (cke[r]) begin
							pw_r <= PW_ACTIVE;
						end
					end
				endcase
			end
		end

		dcap_bank_table #(
			.BANKS(BANKS),
			.ROW_W(16)
		) u_banks (
			.clk(aclk),
			.rst_n(aresetn && dram_reset_n),
			.act(dec[r] && kind == CMD_ACTIVATE),
			.pre_one(dec[r] && ((kind == CMD_PRECHARGE && !ca.addr[`DCAP_AP_BIT]) ||
				(is_rw && ca.addr[`DCAP_AP_BIT]))),
			.pre_all(dec[r] && kind == CMD_PRECHARGE && ca.addr[`DCAP_AP_BIT]),
			.bank(ca.ba),
			.row(ca.addr),
			.open_mask(open_w[r]),
			.sel_row(row_w[r])
		);
	end

	// ==========================================================
	// Mode registers
	// ==========================================================
	logic mode_we;
	logic [2:0] mode_raddr;
	logic [15:0] mode_rdata;

	// Only bank codes zero to three name a mode register.
	assign mode_we = |dec && kind == CMD_LOAD_MODE && !ca.ba[2];

	always_ff @(posedge aclk) begin
		if (!aresetn || !dram_reset_n) begin
			for (int r = 0; r < 2; r++) begin
				mode_reg_zero_r[r] <= `DCAP_MODE_RST;
				mode_reg_one_r[r] <= `DCAP_MODE_RST;
			end
		end else if (mode_we) begin
			if (ca.ba[1:0] == 2'h0) begin
				mode_reg_zero_r[rank_sel] <= ca.addr;
			end
			if (ca.ba[1:0] == 2'h1) begin
				mode_reg_one_r[rank_sel] <= ca.addr;
			end
		end
	end

	dcap_mode_mem #(
		.WORDS(8),
		.W(16)
	) u_mode (
		.clk(aclk),
		.rst_n(aresetn && dram_reset_n),
		.we(mode_we),
		.waddr({rank_sel, ca.ba[1:0]}),
		.wdata(ca.addr),
		.raddr(mode_raddr),
		.rdata(mode_rdata)
	);

	// ==========================================================
	// Command report, data window, strobe and termination
	// ==========================================================
	logic [3:0] beats_r;
	logic wr_win_r;
	logic [31:0] refcnt_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_valid <= 1'b0;
			cmd_report <= '0;
		end else begin
			cmd_valid <= |dec && kind != CMD_NOP;
			if (|dec && kind != CMD_NOP) begin
				cmd_report.rank <= rank_sel;
				cmd_report.kind <= kind;
				cmd_report.bank <= ca.ba;
				cmd_report.auto_pre <= ca.addr[`DCAP_AP_BIT];
				cmd_report.burst8 <= burst8;
				// Read and write report the open row of the addressed bank.
				cmd_report.row <= kind == CMD_ACTIVATE ? ca.addr : row_w[rank_sel];
				cmd_report.col <= col;
			end
		end
	end

	// A new read or write restarts the window; spacing is the controller's duty.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			beats_r <= 4'h0;
			wr_win_r <= 1'b0;
		end else if (|dec && (kind == CMD_READ || kind == CMD_WRITE)) begin
			beats_r <= burst8 ? `DCAP_BEATS8 : `DCAP_BEATS4;
			wr_win_r <= kind == CMD_WRITE;
		end else if (beats_r != 4'h0) begin
			beats_r <= beats_r - 4'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_beat_valid <= 1'b0;
			wr_beat_data <= '0;
			dqs_out <= 1'b0;
		end else begin
			wr_beat_valid <= beats_r != 4'h0 && wr_win_r && !write_byte_mask;
			wr_beat_data <= wr_data;
			dqs_out <= beats_r != 4'h0 && !wr_win_r && !dqs_out;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			term_on <= 2'h0;
		end else begin
			for (int r = 0; r < 2; r++) begin
				term_on[r] <= termination_enable[r] && dram_reset_n && pw_bits[2*r +: 2] != PW_SELF_REF &&
					(mode_reg_one_r[r][`DCAP_MODE_ONE_TERM_A] || mode_reg_one_r[r][`DCAP_MODE_ONE_TERM_B] ||
					mode_reg_one_r[r][`DCAP_MODE_ONE_TERM_C]);
			end
		end
	end

	// Counting refreshes lets software check the controller's refresh rate.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			refcnt_r <= 32'h0;
		end else if (|dec && kind == CMD_REFRESH) begin
			refcnt_r <= refcnt_r + 32'h1;
		end
	end

	// ==========================================================
	// Register bus slave
	// ==========================================================
	logic aw_held_r;
	logic w_held_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic wstrb0_r;
	logic [7:0] araddr_r;
	logic rd_s1_r;
	logic rd_s2_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			aw_held_r <= 1'b0;
			awaddr_r <= 8'h00;
		end else if (awvalid && awready) begin
			awready <= 1'b0;
			aw_held_r <= 1'b1;
			awaddr_r <= awaddr;
		end else if (bvalid && bready) begin
			awready <= 1'b1;
			aw_held_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready <= 1'b1;
			w_held_r <= 1'b0;
			wdata_r <= 32'h0;
			wstrb0_r <= 1'b0;
		end else if (wvalid && wready) begin
			wready <= 1'b0;
			w_held_r <= 1'b1;
			wdata_r <= wdata;
			wstrb0_r <= wstrb[0];
		end else if (bvalid && bready) begin
			wready <= 1'b1;
			w_held_r <= 1'b0;
		end
	end

	// Only the control word is writable; other mapped words ignore writes.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= `DCAP_RESP_OKAY;
			org_x8_r <= `DCAP_CTRL_RST;
		end else if (aw_held_r && w_held_r && !bvalid) begin
			bvalid <= 1'b1;
			bresp <= reg_mapped(awaddr_r) ? `DCAP_RESP_OKAY : `DCAP_RESP_SLVERR;
			if (awaddr_r == `DCAP_OFS_CTRL && wstrb0_r) begin
				org_x8_r <= wdata_r[`DCAP_CTRL_X8_BIT];
			end
		end else if (bvalid && bready) begin
			bvalid <= 1'b0;
		end
	end

	function automatic logic reg_mapped(input logic [7:0] a);
		reg_mapped = a[1:0] == 2'h0 && (a <= `DCAP_OFS_REFCNT ||
			(a >= `DCAP_OFS_MODE && a <= `DCAP_OFS_MODE_END));
	endfunction

	assign mode_raddr = araddr_r[4:2];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			araddr_r <= 8'h00;
			rd_s1_r <= 1'b0;
			rd_s2_r <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= `DCAP_RESP_OKAY;
		end else begin
			rd_s1_r <= arvalid && arready;
			rd_s2_r <= rd_s1_r;
			if (arvalid && arready) begin
				arready <= 1'b0;
				araddr_r <= araddr;
			end else if (rvalid && rready) begin
				arready <= 1'b1;
				rvalid <= 1'b0;
			end
			// The mode word needs one cycle in the memory before it can be returned.
			if (rd_s2_r) begin
				rvalid <= 1'b1;
				rresp <= reg_mapped(araddr_r) ? `DCAP_RESP_OKAY : `DCAP_RESP_SLVERR;
				if (!reg_mapped(araddr_r)) begin
					rdata <= 32'h0;
				end else if (araddr_r >= `DCAP_OFS_MODE) begin
					rdata <= {16'h0, mode_rdata};
				end else begin
					unique case (araddr_r)
						`DCAP_OFS_CTRL: rdata <= {31'h0, org_x8_r};
						`DCAP_OFS_STATUS: rdata <= {12'h0, open_w[1], open_w[0], pw_bits};
						`DCAP_OFS_LASTCMD: rdata <= {23'h0, cmd_report.rank, cmd_report.kind,
							cmd_report.bank, cmd_report.auto_pre, cmd_report.burst8};
						`DCAP_OFS_LASTADR: rdata <= {4'h0, cmd_report.col, cmd_report.row};
						default: rdata <= refcnt_r;
					endcase
				end
			end
		end
	end
endmodule // dcap_top

// *** verification/dcap_top_properties.sv ***
// Concurrent checks on the ports of the DRAM command port.
`timescale 1ns/10ps
module dcap_top_properties
	import dcap_pkg::*;
#(
	parameter int DATA_W = 8
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Pins driven by the controller.
	input wire dcap_ca_t ca,
	input wire logic [1:0] cke,
	input wire logic [1:0] termination_enable,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic write_byte_mask,
	// Design outputs.
	input wire logic [1:0] term_on,
	input wire logic dqs_out,
	input wire logic wr_beat_valid,
	input wire logic [DATA_W-1:0] wr_beat_data,
	input wire logic cmd_valid,
	input wire dcap_report_t cmd_report
);
	// ====
	// Properties
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	rank_sel_a: assert property (cmd_valid |-> $past(ca.cs_n) != 2'b11)
		else $error("Command decoded with no rank selected.");
	cmd_code_a: assert property (cmd_valid |-> cmd_report.kind == $past({ca.ras_n, ca.cas_n, ca.we_n}))
		else $error("Command kind differs from strobe pins.");
	cmd_bank_a: assert property ((cmd_valid && (cmd_report.kind inside {CMD_ACTIVATE, CMD_READ, CMD_WRITE,
		CMD_PRECHARGE})) |-> cmd_report.bank == $past(ca.ba))
		else $error("Command applied to a wrong bank.");
	rank_pick_a: assert property (cmd_valid |-> cmd_report.rank == $past(ca.cs_n[0]))
		else $error("Command reported on the wrong rank.");
	act_row_a: assert property ((cmd_valid && cmd_report.kind == CMD_ACTIVATE) |-> cmd_report.row == $past(ca.addr))
		else $error("Activate row differs from address pins.");
	rw_precharge_a: assert property ((cmd_valid && (cmd_report.kind inside {CMD_READ, CMD_WRITE}))
		|-> cmd_report.auto_pre == $past(ca.addr[10]))
		else $error("Auto precharge bit not taken from pin ten.");
	cke_block_a: assert property (!cke[0] |=> !(cmd_valid && !cmd_report.rank))
		else $error("Rank zero decoded with clock enable low.");
	beat_mask_a: assert property (wr_beat_valid |-> !$past(write_byte_mask) && wr_beat_data == $past(wr_data))
		else $error("Masked or altered write beat passed.");
	term_follow_a: assert property ((term_on & ~$past(termination_enable)) == 2'b00)
		else $error("Termination on without termination enable.");
	cover property (cmd_valid && cmd_report.kind == CMD_ACTIVATE);
	cover property (wr_beat_valid);
	cover property ($rose(dqs_out));
	cover property (term_on[0]);
endmodule // dcap_top_properties

bind dcap_top dcap_top_properties #(.DATA_W(DATA_W)) chk (.aclk, .aresetn, .ca, .cke, .termination_enable, .wr_data,
	.write_byte_mask, .term_on, .dqs_out, .wr_beat_valid, .wr_beat_data, .cmd_valid, .cmd_report);

// *** verification/dcap_ctrl_model.sv ***
// Behavioural memory controller driving the command pins and clock enables.
`timescale 1ns/10ps
module dcap_ctrl_model
	import dcap_pkg::*;
#(
	parameter int GAP = 11
) (
	// Clock.
	input wire logic aclk,
	// Command pins.
	output dcap_ca_t ca,
	output logic [1:0] cke
);
	// ====
	// Command issue
	int refreshes = 0;
	initial begin
		ca = {2'b11, 3'b111, 3'h0, 16'h0000};
		cke = 2'b11;
	end
	// The idle gap before every command covers activate-to-column and precharge spacing of any grade.
	task cmd(input logic [1:0] cs, input logic [2:0] code, input logic [2:0] ba, input logic [15:0] a,
		input logic [1:0] ck);
		repeat (GAP) @(posedge aclk);
		if (cs == 2'b00) cs = 2'b10;
		// A refresh with a clock enable low is self refresh entry, not a counted refresh.
		if (code == 3'b001 && ck == 2'b11) refreshes++;
		ca <= {cs, code, ba, a};
		cke <= ck;
		@(posedge aclk);
		// Idle bank and address pins show the inverse so a stale value is never mistaken for a held one.
		ca <= {2'b11, 3'b111, ~ba, ~a};
	endtask
endmodule // dcap_ctrl_model

// *** verification/testbench.sv ***
// Self-checking bench of the DRAM command port.
`timescale 1ns/10ps
`include "dcap_map.svh"
module testbench;
	import dcap_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, wr_data = 8'h00, wr_beat_data;
	logic [31:0] wdata = 32'h0, rdata, rd;
	logic [3:0] wstrb = 4'hf;
	logic [1:0] bresp, rresp, term_on, rsp;
	logic [1:0] termination_enable = 2'b00;
	logic awready, wready, bvalid, arready, rvalid, dqs_out, wr_beat_valid, cmd_valid;
	logic dram_reset_n = 1'b1, write_byte_mask = 1'b0;
	wire dcap_ca_t ca;
	wire logic [1:0] cke;
	dcap_report_t cmd_report;
	int err_count = 0, comparisons = 0, beats = 0, highs = 0, i;
	// Rows: selects, command code, bank, address pins, expected row or column bits.
	logic [35:0] rows [5] = '{{2'b10, 3'b011, 3'h3, 16'hbeef, 12'heef}, {2'b10, 3'b101, 3'h3, 16'h2abc, 12'hebc},
		{2'b01, 3'b011, 3'h5, 16'h1234, 12'h234}, {2'b01, 3'b100, 3'h5, 16'h0a07, 12'h607},
		{2'b10, 3'b010, 3'h3, 16'h0000, 12'h000}};
	dcap_top uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
		.bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .ca, .cke, .termination_enable,
		.dram_reset_n, .wr_data, .write_byte_mask, .term_on, .dqs_out, .wr_beat_valid, .wr_beat_data, .cmd_valid,
		.cmd_report);
	dcap_ctrl_model ctl (.aclk, .ca, .cke);
	always #5 aclk = ~aclk;
	always @(posedge aclk) begin
		if (wr_beat_valid === 1'b1) beats++;
		if (dqs_out === 1'b1) highs++;
	end
	// ====
	// Tasks
	task give_verdict;
		if (err_count == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task hang;
		err_count++;
		$display("Error at %0t: bus answer never came", $time);
		give_verdict();
	endtask
	task axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		awaddr <= a;
		wdata <= d;
		{awvalid, wvalid, bready} <= 3'b111;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		if (n == 50) hang();
		r = bresp;
		bready <= 1'b0;
		// One edge passes so a following call never drives a ready twice in one step.
		@(posedge aclk);
	endtask
	task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		araddr <= a;
		{arvalid, rready} <= 2'b11;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		if (n == 50) hang();
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask
	// ====
	// Sequence
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		#1;
		chk({awready, wready, arready, bvalid, rvalid, cmd_valid, term_on}, 8'he0);
		for (i = 0; i < 5; i++) begin
			ctl.cmd(rows[i][35:34], rows[i][33:31], rows[i][30:28], rows[i][27:12], 2'b11);
			#1;
			chk({cmd_valid, cmd_report.rank, cmd_report.kind, cmd_report.bank}, {1'b1, rows[i][34], rows[i][33:28]});
			if (rows[i][33:31] == 3'b011) chk(cmd_report.row[11:0], rows[i][11:0]);
			if (rows[i][33] == 1'b1) chk(cmd_report.col, rows[i][11:0]);
		end
		axr(8'h04, rd, rsp);
		chk(rd, 32'h00020000);
		ctl.cmd(2'b10, 3'b011, 3'h1, 16'h0011, 2'b11);
		ctl.cmd(2'b10, 3'b011, 3'h2, 16'h0022, 2'b11);
		ctl.cmd(2'b10, 3'b010, 3'h1, 16'h0000, 2'b11);
		axr(8'h04, rd, rsp);
		chk(rd & 32'hff0, 32'h040);
		ctl.cmd(2'b10, 3'b010, 3'h7, 16'h0400, 2'b11);
		axr(8'h04, rd, rsp);
		chk(rd & 32'hff0, 32'h000);
		for (i = 0; i < 4; i++) ctl.cmd(2'b10, 3'b000, i[2:0], 16'h1230 + i[15:0], 2'b11);
		ctl.cmd(2'b10, 3'b000, 3'h4, 16'hffff, 2'b11);
		for (i = 0; i < 5; i++) begin
			axr(8'h20 + 8'(4 * i), rd, rsp);
			chk(rd, (i < 4) ? 32'h1230 + i : 32'h0);
		end
		termination_enable <= 2'b11;
		repeat (3) @(posedge aclk);
		#1;
		chk(term_on, 2'b01);
		ctl.cmd(2'b10, 3'b000, 3'h1, 16'h0000, 2'b11);
		repeat (2) @(posedge aclk);
		#1;
		chk(term_on, 2'b00);
		ctl.cmd(2'b10, 3'b000, 3'h0, 16'h0001, 2'b11);
		ctl.cmd(2'b10, 3'b011, 3'h0, 16'h0100, 2'b11);
		for (i = 0; i < 2; i++) begin
			ctl.cmd(2'b10, 3'b101, 3'h0, i ? 16'h0000 : 16'h1000, 2'b11);
			highs = 0;
			repeat (14) @(posedge aclk);
			chk(highs, i ? `DCAP_BEATS4 / 2 : `DCAP_BEATS8 / 2);
			chk(cmd_report.burst8, i ? 1'b0 : 1'b1);
		end
		ctl.cmd(2'b10, 3'b100, 3'h0, 16'h1000, 2'b11);
		beats = 0;
		for (i = 1; i <= 8; i++) begin
			wr_data <= 8'(i);
			write_byte_mask <= (i == 3);
			@(posedge aclk);
		end
		write_byte_mask <= 1'b0;
		repeat (3) @(posedge aclk);
		chk(beats, `DCAP_BEATS8 - 1);
		axw(8'h00, 32'h1, rsp);
		ctl.cmd(2'b10, 3'b101, 3'h0, 16'h2abc, 2'b11);
		#1;
		chk(cmd_report.col, 12'h6bc);
		axr(8'h0c, rd, rsp);
		chk(rd, 32'h06bc0100);
		axr(8'h08, rd, rsp);
		chk(rd, 32'h000000a0);
		ctl.cmd(2'b11, 3'b111, 3'h0, 16'h0000, 2'b10);
		ctl.cmd(2'b10, 3'b011, 3'h4, 16'h0000, 2'b10);
		#1;
		chk(cmd_valid, 1'b0);
		axr(8'h04, rd, rsp);
		chk(rd & 32'hff3, 32'h012);
		ctl.cmd(2'b11, 3'b111, 3'h0, 16'h0000, 2'b11);
		ctl.cmd(2'b10, 3'b010, 3'h0, 16'h0400, 2'b11);
		ctl.cmd(2'b11, 3'b111, 3'h0, 16'h0000, 2'b10);
		axr(8'h04, rd, rsp);
		chk(rd & 32'hff3, 32'h001);
		ctl.cmd(2'b11, 3'b111, 3'h0, 16'h0000, 2'b11);
		ctl.cmd(2'b10, 3'b000, 3'h1, 16'h0004, 2'b11);
		ctl.cmd(2'b10, 3'b001, 3'h0, 16'h0000, 2'b10);
		axr(8'h04, rd, rsp);
		chk({term_on, rd[1:0]}, 4'b0011);
		ctl.cmd(2'b11, 3'b111, 3'h0, 16'h0000, 2'b11);
		axr(8'h04, rd, rsp);
		chk({term_on, rd[1:0]}, 4'b0100);
		ctl.cmd(2'b10, 3'b001, 3'h0, 16'h0000, 2'b11);
		axr(8'h10, rd, rsp);
		chk(rd, ctl.refreshes);
		axr(8'h14, rd, rsp);
		chk({rsp, rd[29:0]}, {`DCAP_RESP_SLVERR, 30'h0});
		axw(8'h44, 32'h1, rsp);
		chk(rsp, `DCAP_RESP_SLVERR);
		axw(8'h04, 32'hffffffff, rsp);
		chk(rsp, `DCAP_RESP_OKAY);
		dram_reset_n <= 1'b0;
		repeat (2) @(posedge aclk);
		dram_reset_n <= 1'b1;
		axr(8'h24, rd, rsp);
		chk(rd, 32'h0);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		axr(8'h00, rd, rsp);
		chk(rd, 32'h0);
		give_verdict();
	end
endmodule // testbench
